/* File: src/fspc_params.svh */
// offsets, field positions, reset values and timing counts of the
// flash self-programming controller; included by its design file
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH

// apb byte offsets
`define FSPC_OFS_CTRL      8'h00
`define FSPC_OFS_POINTER   8'h04
`define FSPC_OFS_DATA      8'h08
`define FSPC_OFS_INSN      8'h0C
`define FSPC_OFS_LOAD_RES  8'h10

// prog_ctrl_status_reg bit positions
`define FSPC_BIT_SELF_PROG 0
`define FSPC_BIT_PG_ERASE  1
`define FSPC_BIT_PG_WRITE  2
`define FSPC_BIT_LOCK_FUSE 3
`define FSPC_BIT_REENABLE  4
`define FSPC_BIT_SECT_BUSY 6
`define FSPC_BIT_IRQ_EN    7

// instruction register bits
`define FSPC_BIT_STORE     0
`define FSPC_BIT_LOAD      1

// command codes in the low five control bits
`define FSPC_CODE_LOAD     5'h01
`define FSPC_CODE_ERASE    5'h03
`define FSPC_CODE_WRITE    5'h05
`define FSPC_CODE_LOCK     5'h09
`define FSPC_CODE_REEN     5'h11

// pointer layout: word index and page number
`define FSPC_WORD_LSB      1
`define FSPC_WORD_MSB      6
`define FSPC_PAGE_LSB      7
`define FSPC_PAGE_MSB      14
`define FSPC_PAGE_WORDS    64
`define FSPC_HALT_PAGE0    8'hE0

// lock and fuse read selectors
`define FSPC_PTR_FUSE_LO   16'h0000
`define FSPC_PTR_LOCK      16'h0001
`define FSPC_PTR_FUSE_EXT  16'h0002
`define FSPC_PTR_FUSE_HI   16'h0003

// reset and fill values
`define FSPC_CTRL_RST      8'h00
`define FSPC_BYTE_ONES     8'hFF
`define FSPC_WORD_ERASED   16'hFFFF

// timed windows in core cycles
`define FSPC_STORE_WIN     3'h4
`define FSPC_LOAD_WIN      3'h3
`define FSPC_LOAD_MIN_CNT  (`FSPC_STORE_WIN - `FSPC_LOAD_WIN + 3'h1)

`endif

/* File: src/fspc_pkg.sv */
// types shared by the flash self-programming controller
// numeric widths are written out here; the params header is not included
package fspc_pkg;

  typedef enum logic [1:0] {
    FSPC_OP_NONE,
    FSPC_OP_ERASE,
    FSPC_OP_WRITE,
    FSPC_OP_LOCK
  } fspc_op_t;

  typedef enum logic {
    FSPC_ST_IDLE,
    FSPC_ST_RUN
  } fspc_state_t;

  typedef struct packed {
    logic       start;
    fspc_op_t   op;
    logic [7:0] page;
    logic [7:0] lock_data;
  } fspc_flash_req_t;

  typedef struct packed {
    logic        req;
    logic [14:0] addr;
  } fspc_flash_rd_t;

endpackage

/* File: src/fspc_ctrl.sv */
// flash self-programming controller: apb registers, timed store/load
// windows, temporary page buffer, flash macro sequencing
// assumes a flash macro that answers each start with a done pulse
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "fspc_params.svh"

module fspc_ctrl (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     eeprom_write_busy,
  input  wire logic [7:0]               fuse_low_byte,
  input  wire logic [7:0]               fuse_high_byte,
  input  wire logic [2:0]               fuse_extended_byte,
  input  wire logic [5:0]               lock_bits_state,
  output fspc_pkg::fspc_flash_req_t     flash_req,
  input  wire logic                     flash_done,
  input  wire logic [5:0]               flash_buf_idx,
  output logic      [15:0]              flash_buf_word,
  output fspc_pkg::fspc_flash_rd_t      flash_rd,
  input  wire logic [7:0]               flash_rd_data,
  output logic                          cpu_halt,
  output logic                          concurrent_read_block,
  output logic                          spm_irq
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic fspc_pkg::fspc_op_t op_of(input logic [4:0] code);
    unique case (code)
      `FSPC_CODE_ERASE: op_of = fspc_pkg::FSPC_OP_ERASE;
      `FSPC_CODE_WRITE: op_of = fspc_pkg::FSPC_OP_WRITE;
      `FSPC_CODE_LOCK:  op_of = fspc_pkg::FSPC_OP_LOCK;
      default:          op_of = fspc_pkg::FSPC_OP_NONE;
    endcase
  endfunction

  function automatic logic [7:0] page_of(input logic [15:0] ptr);
    page_of = ptr[`FSPC_PAGE_MSB:`FSPC_PAGE_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]              ctrl_ff;
  logic [15:0]             pointer_ff;
  logic [15:0]             data_ff;
  logic [7:0]              load_res_ff;
  logic [2:0]              win_cnt_ff;
  logic                    sect_busy_ff;
  logic                    rd_pend_ff;
  fspc_pkg::fspc_state_t   state_ff;
  fspc_pkg::fspc_op_t      op_ff;
  logic [7:0]              op_page_ff;
  logic                    op_halt_ff;
  logic [15:0]             buf_mem [`FSPC_PAGE_WORDS];
  logic [`FSPC_PAGE_WORDS-1:0] buf_valid_ff;

  logic                    acc;
  logic                    wr_ctrl;
  logic                    wr_ptr;
  logic                    wr_data;
  logic                    store_evt;
  logic                    load_evt;
  logic                    enabled;
  logic                    in_store_win;
  logic                    in_load_win;
  logic                    store_ok;
  logic                    op_start;
  logic                    op_end;
  logic                    lf_read;
  logic                    buf_load;
  logic                    buf_clear;
  logic [5:0]              word_idx;
  fspc_pkg::fspc_op_t      nxt_op;

  ////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer in second cycle

  assign acc     = psel & penable & pready;
  assign wr_ctrl = acc & pwrite & (paddr == `FSPC_OFS_CTRL);
  assign wr_ptr  = acc & pwrite & (paddr == `FSPC_OFS_POINTER);
  assign wr_data = acc & pwrite & (paddr == `FSPC_OFS_DATA);
  assign store_evt = acc & pwrite & (paddr == `FSPC_OFS_INSN) &
                     pwdata[`FSPC_BIT_STORE];
  assign load_evt  = acc & pwrite & (paddr == `FSPC_OFS_INSN) &
                     pwdata[`FSPC_BIT_LOAD];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (paddr)
        `FSPC_OFS_CTRL:     prdata[7:0] <= {ctrl_ff[7], sect_busy_ff,
                                            1'b0, ctrl_ff[4:0]};
        `FSPC_OFS_POINTER:  prdata[15:0] <= pointer_ff;
        `FSPC_OFS_DATA:     prdata[15:0] <= data_ff;
        `FSPC_OFS_INSN:     prdata <= 32'h0000_0000;
        `FSPC_OFS_LOAD_RES: prdata[7:0] <= load_res_ff;
        default:            pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pointer_ff <= 16'h0000;
      data_ff    <= 16'h0000;
    end else begin
      if (wr_ptr)
        pointer_ff <= pwdata[15:0];
      if (wr_data)
        data_ff <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timed windows and control register

  assign enabled      = ctrl_ff[`FSPC_BIT_SELF_PROG];
  assign in_store_win = (win_cnt_ff != 3'h0);
  assign in_load_win  = (win_cnt_ff >= `FSPC_LOAD_MIN_CNT);
  // eeprom write blocks every programming step
  assign store_ok = store_evt & enabled & in_store_win &
                    (state_ff == fspc_pkg::FSPC_ST_IDLE) &
                    ~eeprom_write_busy;
  assign nxt_op   = op_of(ctrl_ff[4:0]);
  assign op_start = store_ok & (nxt_op != fspc_pkg::FSPC_OP_NONE);
  assign op_end   = (state_ff == fspc_pkg::FSPC_ST_RUN) & flash_done;
  assign lf_read  = load_evt & enabled & ctrl_ff[`FSPC_BIT_LOCK_FUSE] &
                    in_load_win & ~eeprom_write_busy;
  assign buf_load = store_ok & (ctrl_ff[4:0] == `FSPC_CODE_LOAD);
  assign word_idx = pointer_ff[`FSPC_WORD_MSB:`FSPC_WORD_LSB];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= `FSPC_CTRL_RST;
      win_cnt_ff <= 3'h0;
    end else if (wr_ctrl && !enabled && !eeprom_write_busy) begin
      ctrl_ff    <= {pwdata[7], 2'b00, pwdata[4:0]};
      win_cnt_ff <= pwdata[`FSPC_BIT_SELF_PROG] ? `FSPC_STORE_WIN : 3'h0;
    end else if (op_start) begin
      win_cnt_ff <= 3'h0;
    end else if (op_end) begin
      ctrl_ff[4:0] <= 5'h00;
    end else if (store_ok || lf_read) begin
      ctrl_ff[4:0] <= 5'h00;
      win_cnt_ff   <= 3'h0;
    end else if (in_store_win) begin
      win_cnt_ff <= win_cnt_ff - 3'h1;
      if (win_cnt_ff == 3'h1)
        ctrl_ff[4:0] <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operation sequencer

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= fspc_pkg::FSPC_ST_IDLE;
      op_ff      <= fspc_pkg::FSPC_OP_NONE;
      op_page_ff <= 8'h00;
      op_halt_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        fspc_pkg::FSPC_ST_IDLE: begin
          if (op_start) begin
            state_ff   <= fspc_pkg::FSPC_ST_RUN;
            op_ff      <= nxt_op;
            op_page_ff <= page_of(pointer_ff);
            // lock programming never halts
            op_halt_ff <= (nxt_op != fspc_pkg::FSPC_OP_LOCK) &&
                          (page_of(pointer_ff) >= `FSPC_HALT_PAGE0);
          end
        end
        fspc_pkg::FSPC_ST_RUN: begin
          if (flash_done) begin
            state_ff   <= fspc_pkg::FSPC_ST_IDLE;
            op_ff      <= fspc_pkg::FSPC_OP_NONE;
            op_halt_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flash_req <= '0;
    end else begin
      flash_req.start <= op_start;
      if (op_start) begin
        flash_req.op        <= nxt_op;
        // erase and write take only the page field
        flash_req.page      <= page_of(pointer_ff);
        // lock programming uses data bits 5:0 only
        flash_req.lock_data <= {2'b11, data_ff[5:0]};
      end
    end
  end

  // busy flag and read blocking
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sect_busy_ff   <= 1'b0;
      concurrent_read_block <= 1'b0;
      cpu_halt       <= 1'b0;
      spm_irq        <= 1'b0;
    end else begin
      if (op_start && nxt_op != fspc_pkg::FSPC_OP_LOCK)
        sect_busy_ff <= 1'b1;
      else if (store_ok && ctrl_ff[4:0] == `FSPC_CODE_REEN)
        sect_busy_ff <= 1'b0;
      concurrent_read_block <= !flash_done &&
                               (state_ff == fspc_pkg::FSPC_ST_RUN) &&
                               (op_ff != fspc_pkg::FSPC_OP_LOCK);
      cpu_halt <= op_halt_ff && !flash_done;
      spm_irq  <= ctrl_ff[`FSPC_BIT_IRQ_EN] && !enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // temporary page buffer

  assign buf_clear = (op_end && op_ff == fspc_pkg::FSPC_OP_WRITE) ||
                     (store_ok && ctrl_ff[4:0] == `FSPC_CODE_REEN) ||
                     (eeprom_write_busy && (buf_valid_ff != '0));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_valid_ff <= '0;
    end else if (buf_clear) begin
      buf_valid_ff <= '0;
    end else if (buf_load) begin
      buf_valid_ff[word_idx] <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (buf_load)
      buf_mem[word_idx] <= data_ff;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      flash_buf_word <= `FSPC_WORD_ERASED;
    else if (buf_valid_ff[flash_buf_idx])
      flash_buf_word <= buf_mem[flash_buf_idx];
    else
      flash_buf_word <= `FSPC_WORD_ERASED;
  end

  ////////////////////////////////////////////////////////////////////
  // load instruction: lock/fuse window or byte read of flash

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flash_rd    <= '0;
      rd_pend_ff  <= 1'b0;
      load_res_ff <= 8'h00;
    end else begin
      flash_rd.req <= 1'b0;
      // flash answers in the cycle after the request pulse
      rd_pend_ff   <= flash_rd.req;
      if (rd_pend_ff)
        load_res_ff <= flash_rd_data;
      if (lf_read) begin
        unique case (pointer_ff)
          `FSPC_PTR_FUSE_LO:  load_res_ff <= fuse_low_byte;
          `FSPC_PTR_LOCK:     load_res_ff <= {2'b11,
                                              lock_bits_state};
          `FSPC_PTR_FUSE_EXT: load_res_ff <= {5'b11111,
                                              fuse_extended_byte};
          `FSPC_PTR_FUSE_HI:  load_res_ff <= fuse_high_byte;
          default:            load_res_ff <= `FSPC_BYTE_ONES;
        endcase
      end else if (load_evt && enabled && ctrl_ff[`FSPC_BIT_LOCK_FUSE]) begin
        // window read refused while eeprom busy or outside the load window
        load_res_ff <= `FSPC_BYTE_ONES;
      end else if (load_evt) begin
        if (concurrent_read_block &&
            page_of(pointer_ff) < `FSPC_HALT_PAGE0) begin
          load_res_ff <= `FSPC_BYTE_ONES;
        end else begin
          flash_rd.req  <= 1'b1;
          flash_rd.addr <= pointer_ff[14:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_erase_armed;
    enabled && ctrl_ff[4:0] == `FSPC_CODE_ERASE && in_store_win;
  endsequence
  sequence s_store_now;
    store_evt && !eeprom_write_busy &&
    state_ff == fspc_pkg::FSPC_ST_IDLE;
  endsequence

  AST_ERASE_STARTS: assert property (
    s_erase_armed and s_store_now |=>
      flash_req.start && flash_req.op == fspc_pkg::FSPC_OP_ERASE)
    else $error("erase not started after timed store");
  AST_PAGE_LATCHED: assert property (
    op_start |=> flash_req.page == page_of($past(pointer_ff)) &&
                 op_page_ff == flash_req.page)
    else $error("page not captured at start");
  AST_WINDOW_EXPIRES: assert property (
    wr_ctrl && !enabled && !eeprom_write_busy &&
    pwdata[`FSPC_BIT_SELF_PROG] ##1 (!store_evt && !load_evt)[*4]
      |=> !enabled)
    else $error("enable bit not cleared after window");
  AST_ENABLE_HELD: assert property (
    state_ff == fspc_pkg::FSPC_ST_RUN && !flash_done |=> enabled)
    else $error("enable bit dropped during operation");
  AST_IRQ_LEVEL: assert property (
    ctrl_ff[`FSPC_BIT_IRQ_EN] && !enabled &&
    $past(ctrl_ff[`FSPC_BIT_IRQ_EN] && !enabled) |-> spm_irq)
    else $error("interrupt not held while enable clear");
  AST_EEP_BLOCKS: assert property (
    eeprom_write_busy |=> !flash_req.start)
    else $error("programming started during eeprom write");
  AST_LOCK_NO_HALT: assert property (
    op_ff == fspc_pkg::FSPC_OP_LOCK
      |=> !cpu_halt && !concurrent_read_block)
    else $error("lock programming halted or blocked reads");
  AST_BUSY_STICKY: assert property (
    sect_busy_ff && !(store_ok && ctrl_ff[4:0] == `FSPC_CODE_REEN)
      |=> sect_busy_ff)
    else $error("section busy flag cleared without re-enable");
  AST_BUF_CLR_WRITE: assert property (
    op_end && op_ff == fspc_pkg::FSPC_OP_WRITE |=> buf_valid_ff == '0)
    else $error("buffer not cleared after page write");
  AST_FUSE_LO_READ: assert property (
    lf_read && pointer_ff == `FSPC_PTR_FUSE_LO
      |=> load_res_ff == $past(fuse_low_byte))
    else $error("fuse low byte not returned");

endmodule // fspc_ctrl

/* File: bench/fspc_flash_model.sv */
// flash macro model: a done pulse dly+1 cycles after each start, and an
// address-derived byte in the cycle after each read request
// assumes the controller pulses start and read request for one cycle
`timescale 1ns/1ps

module fspc_flash_model (
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic [7:0]                dly,
  input  wire fspc_pkg::fspc_flash_req_t req,
  input  wire fspc_pkg::fspc_flash_rd_t  rd,
  output logic                           done,
  output logic      [7:0]                rd_data,
  output fspc_pkg::fspc_flash_req_t      last
);
  logic [7:0] cnt_ff;
  logic       run_ff;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
      done   <= 1'b0;
      last   <= '0;
    end else begin
      done <= 1'b0;
      if (req.start) begin
        run_ff <= 1'b1;
        cnt_ff <= dly;
        last   <= req;
      end else if (run_ff && cnt_ff == 8'h00) begin
        run_ff <= 1'b0;
        done   <= 1'b1;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outside the sampled cycle the data toggles so stale reads show
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rd_data <= 8'h00;
    else if (rd.req)
      rd_data <= rd.addr[7:0] ^ {1'b0, rd.addr[14:8]};
    else
      rd_data <= ~rd_data;
  end
endmodule // fspc_flash_model

/* File: bench/tb.sv */
// self-checking testbench of the flash self-programming controller
// assumes the params header, package and flash model are compiled first
`timescale 1ns/1ps
`include "fspc_params.svh"

module tb;
  logic                      mclk, reset_n, psel, penable, pwrite, perr;
  logic                      pready, pslverr, ee_busy, flash_done;
  logic                      cpu_halt, conc_block, spm_irq;
  logic [7:0]                paddr, fuse_lo, fuse_hi, rd_data, dly;
  logic [31:0]               pwdata, prdata, rv;
  logic [2:0]                fuse_ext;
  logic [5:0]                lock_st, buf_idx, wi0, wi1;
  logic [15:0]               buf_word, lf_ff, r, ptr, d0, d1;
  fspc_pkg::fspc_flash_req_t flash_req, last;
  fspc_pkg::fspc_flash_rd_t  flash_rd;
  int                        error_cnt, comparisons, p;

  fspc_ctrl DUT (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_write_busy(ee_busy), .fuse_low_byte(fuse_lo),
    .fuse_high_byte(fuse_hi), .fuse_extended_byte(fuse_ext),
    .lock_bits_state(lock_st), .flash_req(flash_req),
    .flash_done(flash_done), .flash_buf_idx(buf_idx),
    .flash_buf_word(buf_word), .flash_rd(flash_rd),
    .flash_rd_data(rd_data), .cpu_halt(cpu_halt),
    .concurrent_read_block(conc_block), .spm_irq(spm_irq));

  fspc_flash_model flash (.mclk(mclk), .reset_n(reset_n), .dly(dly),
    .req(flash_req), .rd(flash_rd), .done(flash_done),
    .rd_data(rd_data), .last(last));

  always #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lf();
    lf_ff = {lf_ff[14:0], lf_ff[15] ^ lf_ff[13] ^ lf_ff[12] ^ lf_ff[10]};
    return lf_ff;
  endfunction

  function automatic logic [7:0] fuse_exp(input int q);
    case (q)
      0: return fuse_lo;
      1: return {2'h3, lock_st};
      2: return {5'h1F, fuse_ext};
      default: return fuse_hi;
    endcase
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      end_of_test();
    end
    rv = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // store lands three edges after the control write, inside the window
  task automatic prog(input logic [7:0] c, input logic [15:0] a,
                      input logic [15:0] d);
    apb(1'b1, `FSPC_OFS_POINTER, {16'h0000, a});
    apb(1'b1, `FSPC_OFS_DATA, {16'h0000, d});
    apb(1'b1, `FSPC_OFS_CTRL, {24'h00_0000, c});
    apb(1'b1, `FSPC_OFS_INSN, 32'h0000_0001);
  endtask

  task automatic buf_chk(input logic [5:0] i, input logic [15:0] e);
    @(posedge mclk);
    buf_idx <= i;
    repeat (2) @(posedge mclk);
    chk({16'h0000, buf_word}, {16'h0000, e});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    {reset_n, psel, penable, pwrite, ee_busy} = 5'h00;
    {paddr, pwdata, buf_idx, dly} = '0;
    {error_cnt, comparisons} = '0;
    lf_ff = 16'h0057;
    r = lf();
    {fuse_lo, fuse_hi} = r;
    r = lf();
    {fuse_ext, lock_st} = r[8:0];
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, perr}, 32'h1);
    r = lf();
    buf_chk(r[5:0], 16'hFFFF);
    r = lf();
    wi0 = r[5:0];
    wi1 = r[5:0] ^ 6'h2A;
    d0 = lf();
    d1 = lf();
    r = lf();
    prog(8'h01, {r[15:7], wi0, r[0]}, d0);
    prog(8'h01, {r[8:0], wi1, r[15]}, d1);
    buf_chk(wi0, d0);
    buf_chk(wi1, d1);
    ee_busy <= 1'b1;
    apb(1'b1, `FSPC_OFS_CTRL, 32'h0000_0009);
    apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
    chk(rv, 32'h0);
    ee_busy <= 1'b0;
    buf_chk(wi1, 16'hFFFF);
    r = lf();
    dly <= {3'h0, r[4:0]} + 8'h10;
    ptr = {2'h0, r[13:0]};
    prog(8'h83, ptr, lf());
    apb(1'b1, `FSPC_OFS_POINTER, 32'h0000_7FFF);
    chk({30'h0, conc_block, cpu_halt}, 32'h2);
    apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
    chk(rv & 32'h0000_0041, 32'h0000_0041);
    chk({31'h0, spm_irq}, 32'h0);
    wait_idle();
    chk({22'h0, last.op, last.page},
        {22'h0, fspc_pkg::FSPC_OP_ERASE, ptr[14:7]});
    chk({31'h0, spm_irq}, 32'h1);
    prog(8'h01, {9'h000, wi0, 1'b0}, d0);
    prog(8'h11, 16'h0000, 16'h0000);
    apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
    chk(rv & 32'h0000_0040, 32'h0);
    buf_chk(wi0, 16'hFFFF);
    prog(8'h01, {9'h000, wi0, 1'b0}, d0);
    r = lf();
    ptr = {1'b0, 3'h7, r[4:0], 7'h00};
    prog(8'h05, ptr, lf());
    repeat (4) @(posedge mclk);
    chk({30'h0, conc_block, cpu_halt}, 32'h3);
    wait_idle();
    chk({22'h0, last.op, last.page},
        {22'h0, fspc_pkg::FSPC_OP_WRITE, ptr[14:7]});
    buf_chk(wi0, 16'hFFFF);
    prog(8'h11, 16'h0000, 16'h0000);
    r = lf();
    prog(8'h09, 16'h0001, {8'h00, 2'h3, r[5:0]});
    repeat (4) @(posedge mclk);
    chk({30'h0, conc_block, cpu_halt}, 32'h0);
    wait_idle();
    chk({22'h0, last.op, last.lock_data},
        {22'h0, fspc_pkg::FSPC_OP_LOCK, 2'h3, r[5:0]});
    for (p = 0; p < 4; p++) begin
      apb(1'b1, `FSPC_OFS_POINTER, 32'(p));
      apb(1'b1, `FSPC_OFS_CTRL, 32'h0000_0009);
      apb(1'b1, `FSPC_OFS_INSN, 32'h0000_0002);
      apb(1'b0, `FSPC_OFS_LOAD_RES, 32'h0);
      chk(rv, {24'h0, fuse_exp(p)});
      apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
      chk(rv & 32'h0000_001F, 32'h0);
    end
    apb(1'b1, `FSPC_OFS_CTRL, 32'h0000_0001);
    repeat (6) @(posedge mclk);
    apb(1'b0, `FSPC_OFS_CTRL, 32'h0);
    chk(rv & 32'h0000_001F, 32'h0);
    apb(1'b1, `FSPC_OFS_CTRL, 32'h0000_0009);
    ee_busy <= 1'b1;
    apb(1'b1, `FSPC_OFS_INSN, 32'h0000_0002);
    ee_busy <= 1'b0;
    apb(1'b0, `FSPC_OFS_LOAD_RES, 32'h0);
    chk(rv, 32'h0000_00FF);
    for (p = 0; p < 2; p++) begin
      r = lf();
      ptr = {1'b0, r[14:1], p[0]};
      apb(1'b1, `FSPC_OFS_POINTER, {16'h0000, ptr});
      apb(1'b1, `FSPC_OFS_INSN, 32'h0000_0002);
      repeat (2) @(posedge mclk);
      apb(1'b0, `FSPC_OFS_LOAD_RES, 32'h0);
      chk(rv, {24'h0, ptr[7:0] ^ {1'b0, ptr[14:8]}});
    end
    end_of_test();
  end
endmodule // tb
